/* hbu_map.svh */
// Register offsets, field positions and reset values of the breakpoint unit
`ifndef HBU_MAP_SVH
`define HBU_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define HBU_OFS_CTRL0    8'h00
`define HBU_OFS_CTRL1    8'h04
`define HBU_OFS_ADDR_HI  8'h08
`define HBU_OFS_ADDR_LO  8'h0C
`define HBU_OFS_DATA_HI  8'h10
`define HBU_OFS_DATA_LO  8'h14
`define HBU_OFS_STATUS   8'h18

// ----------------------------------------------------------------------
// Control 0 fields
// ----------------------------------------------------------------------
`define HBU_C0_EN_HI     7
`define HBU_C0_EN_LO     6
`define HBU_C0_PROG      3
`define HBU_C0_RANGE1    1
`define HBU_C0_RANGE0    0

// ----------------------------------------------------------------------
// Control 1 fields
// ----------------------------------------------------------------------
`define HBU_C1_DBE       6
`define HBU_C1_MBH       5
`define HBU_C1_MBL       4
`define HBU_C1_RWE1      3
`define HBU_C1_RW1       2
`define HBU_C1_RWE0      1
`define HBU_C1_RW0       0

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define HBU_CTRL0_RST    8'h00
`define HBU_CTRL1_RST    8'h00
`define HBU_CMP_RST      8'h00
`define HBU_CTRL0_MASK   8'hCB
`define HBU_CTRL1_MASK   8'h7F
`define HBU_CMP_MASK     8'hFF

`endif

/* hbu_pkg.sv */
// Types shared by the breakpoint unit files
package hbu_pkg;
  // Breakpoint mode from the two mode enable bits
  typedef enum logic [1:0] {
    HBU_OFF       = 2'b00,
    HBU_SWI_DUAL  = 2'b01,
    HBU_BDM_FULL  = 2'b10,
    HBU_BDM_DUAL  = 2'b11
  } hbu_mode_t;

  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    HBU_ST_IDLE = 2'b01,
    HBU_ST_DATA = 2'b10
  } hbu_state_t;
endpackage

/* hbu_compare.sv */
// One address breakpoint comparator with range and read/write match
`timescale 1ns/1ps
module hbu_compare
  import hbu_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic        rw,
  input  wire logic [7:0]  cmp_hi,
  input  wire logic [7:0]  cmp_lo,
  input  wire logic        range_full,
  input  wire logic        rw_en,
  input  wire logic        rw_val,
  output logic             hit
);
  // High byte always; low byte only with full range; r/w optional
  always_comb begin
    hit = (addr[15:8] == cmp_hi)
        && (!range_full || addr[7:0] == cmp_lo)
        && (!rw_en || rw == rw_val);
  end
endmodule // hbu_compare

/* hbu_cmp_regs.sv */
// Four compare registers cleared only by power-on reset
`timescale 1ns/1ps
`include "hbu_map.svh"
module hbu_cmp_regs
  import hbu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       por,
  input  wire logic       we,
  input  wire logic [1:0] sel,
  input  wire logic [7:0] wdata,
  output logic [7:0]      addr_hi_q,
  output logic [7:0]      addr_lo_q,
  output logic [7:0]      data_hi_q,
  output logic [7:0]      data_lo_q
);
  // Only power-on clears these; ordinary reset keeps the setup
  always_ff @(posedge clk or posedge por) begin
    if (por) begin
      addr_hi_q <= `HBU_CMP_RST;
      addr_lo_q <= `HBU_CMP_RST;
      data_hi_q <= `HBU_CMP_RST;
      data_lo_q <= `HBU_CMP_RST;
    end else if (we) begin
      case (sel)
        2'h0:    addr_hi_q <= wdata;
        2'h1:    addr_lo_q <= wdata;
        2'h2:    data_hi_q <= wdata;
        default: data_lo_q <= wdata;
      endcase
    end
  end
endmodule // hbu_cmp_regs

/* hbu_top.sv */
// Hardware breakpoint unit: AHB-Lite registers and bus comparators
`timescale 1ns/1ps
`include "hbu_map.svh"

// Summary of operation
// - Two enable bits select off or three modes
// - No breakpoints while debug mode active
// - Only dual interrupt mode raises software interrupt
// - Interrupt mode ignores r/w and byte masks
// - Data enable arms second address breakpoint
// - Full mode ignores second range and r/w
// - Full mode data compare unless program-only
// - Program-only tags opcode, else immediate break
// - Interrupt mode always uses tagged breaks
// - Dual debug mode honours range, and r/w unless program-only
// - Dual debug entry needs debug enable
// - First range bit adds low address byte
// - Second range bit adds low data register
// - Data enable clear excludes data registers
// - High mask excludes data bits 15:8
// - Low mask excludes data bits 7:0
// - First r/w compare: 0 write, 1 read
// - Second r/w compare: 0 write, 1 read
// - Data registers hit data or address bus
// - Address high always, low by range bit
// - Power-on clears compare registers only
// - Control registers accessible at all times
// - Tagged opcode at queue head enters debug
// - Debug enable gates dual mode debug activation; full mode ignores it
module hbu_top
  import hbu_pkg::*;
#(
  parameter int ADDR_W = 16
)(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        por,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        cpu_valid,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [15:0] cpu_data,
  input  wire logic        cpu_rw,
  input  wire logic        cpu_fetch,
  input  wire logic        debug_active,
  input  wire logic        debug_mode_enable,
  output logic             swi_req_q,
  output logic             bdm_req_q,
  output logic             tag_req_q
);
  // Elaboration check: the comparators are built for a 16-bit bus only
  if (ADDR_W != 16) begin : g_bad_addr_w
    $error("hbu_top: only 16-bit address supported");
  end

  // --------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------
  hbu_state_t  state_q;
  logic [7:0]  ctrl0_q;
  logic [7:0]  ctrl1_q;
  logic [7:0]  wofs_q;
  logic        wr_pend_q;
  logic [7:0]  ah;
  logic [7:0]  al;
  logic [7:0]  dh;
  logic [7:0]  dl;
  logic        take;
  logic        cmp_we;
  logic [7:0]  stat;
  logic [2:0]  cmp_idx;

  // Bits software can write at an offset; zero where nothing lands
  function automatic logic [7:0] wr_mask(input logic [7:0] ofs);
    case (ofs)
      `HBU_OFS_CTRL0:   wr_mask = `HBU_CTRL0_MASK;
      `HBU_OFS_CTRL1:   wr_mask = `HBU_CTRL1_MASK;
      `HBU_OFS_ADDR_HI: wr_mask = `HBU_CMP_MASK;
      `HBU_OFS_ADDR_LO: wr_mask = `HBU_CMP_MASK;
      `HBU_OFS_DATA_HI: wr_mask = `HBU_CMP_MASK;
      `HBU_OFS_DATA_LO: wr_mask = `HBU_CMP_MASK;
      default:          wr_mask = 8'h00;
    endcase
  endfunction

  // Valid request in an address phase
  assign take = hsel && hready && htrans[1];

  // Phase tracking and captured write offset; zero wait states
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q   <= HBU_ST_IDLE;
      wofs_q    <= 8'h00;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite;
      if (take) begin
        wofs_q <= haddr[7:0];
        state_q <= HBU_ST_DATA;
      end else begin
        state_q <= HBU_ST_IDLE;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Control registers, writable in any mode
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl0_q <= `HBU_CTRL0_RST;
      ctrl1_q <= `HBU_CTRL1_RST;
    end else if (wr_pend_q) begin
      if (wofs_q == `HBU_OFS_CTRL0)
        ctrl0_q <= hwdata[7:0] & wr_mask(wofs_q);
      if (wofs_q == `HBU_OFS_CTRL1)
        ctrl1_q <= hwdata[7:0] & wr_mask(wofs_q);
    end
  end

  // Compare register write strobe decode
  always_comb begin
    cmp_we = wr_pend_q && (wofs_q == `HBU_OFS_ADDR_HI ||
             wofs_q == `HBU_OFS_ADDR_LO || wofs_q == `HBU_OFS_DATA_HI ||
             wofs_q == `HBU_OFS_DATA_LO);
  end

  // Compare words run upward from the high address byte; only
  // meaningful while the compare write strobe is high
  assign cmp_idx = wofs_q[4:2] - 3'h2;

  hbu_cmp_regs u_regs (
    .clk       (clk),
    .por       (por),
    .we        (cmp_we),
    .sel       (cmp_idx[1:0]),
    .wdata     (hwdata[7:0]),
    .addr_hi_q (ah),
    .addr_lo_q (al),
    .data_hi_q (dh),
    .data_lo_q (dl)
  );

  assign stat = {5'h00, tag_req_q, bdm_req_q, swi_req_q};

  // Read data registered at the address phase; unmapped reads zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      if (wr_pend_q && wofs_q == haddr[7:0] &&
          wofs_q != `HBU_OFS_STATUS) begin
        // Back-to-back read of the word being written sees the new value
        hrdata <= {24'h000000, hwdata[7:0] & wr_mask(wofs_q)};
      end else begin
        case (haddr[7:0])
          `HBU_OFS_CTRL0:   hrdata <= {24'h000000, ctrl0_q};
          `HBU_OFS_CTRL1:   hrdata <= {24'h000000, ctrl1_q};
          `HBU_OFS_ADDR_HI: hrdata <= {24'h000000, ah};
          `HBU_OFS_ADDR_LO: hrdata <= {24'h000000, al};
          `HBU_OFS_DATA_HI: hrdata <= {24'h000000, dh};
          `HBU_OFS_DATA_LO: hrdata <= {24'h000000, dl};
          `HBU_OFS_STATUS:  hrdata <= {24'h000000, stat};
          default:          hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Match logic
  // --------------------------------------------------------------------
  hbu_mode_t mode;
  logic      prog, dbe;
  logic      dual, full, rw_ok;
  logic      hit0, hit1;
  logic      bp0_raw, bp1_raw;
  logic      data_ok;
  logic      any_hit;
  logic      can_bdm;

  assign mode  = hbu_mode_t'({ctrl0_q[`HBU_C0_EN_HI],
                              ctrl0_q[`HBU_C0_EN_LO]});
  assign dual  = (mode == HBU_SWI_DUAL) || (mode == HBU_BDM_DUAL);
  assign full  = (mode == HBU_BDM_FULL);
  assign dbe   = ctrl1_q[`HBU_C1_DBE];
  // Interrupt mode is always tagged; elsewhere program-only bit decides
  assign prog  = (mode == HBU_SWI_DUAL) || ctrl0_q[`HBU_C0_PROG];
  // r/w bits only apply to debug modes without tagging
  assign rw_ok = (mode != HBU_SWI_DUAL) && !prog;

  // First breakpoint: address registers, own range and r/w
  hbu_compare u_bp0 (
    .addr       (cpu_addr),
    .rw         (cpu_rw),
    .cmp_hi     (ah),
    .cmp_lo     (al),
    .range_full (ctrl0_q[`HBU_C0_RANGE0]),
    .rw_en      (rw_ok && ctrl1_q[`HBU_C1_RWE0]),
    .rw_val     (ctrl1_q[`HBU_C1_RW0]),
    .hit        (hit0)
  );

  // Second breakpoint: data registers used as an address
  hbu_compare u_bp1 (
    .addr       (cpu_addr),
    .rw         (cpu_rw),
    .cmp_hi     (dh),
    .cmp_lo     (dl),
    .range_full (ctrl0_q[`HBU_C0_RANGE1]),
    .rw_en      (rw_ok && ctrl1_q[`HBU_C1_RWE1]),
    .rw_val     (ctrl1_q[`HBU_C1_RW1]),
    .hit        (hit1)
  );

  // Full mode data compare with byte masks; dropped when tagging
  always_comb begin
    data_ok = 1'b1;
    if (dbe && !prog) begin
      if (!ctrl1_q[`HBU_C1_MBH] && cpu_data[15:8] != dh)
        data_ok = 1'b0;
      if (!ctrl1_q[`HBU_C1_MBL] && cpu_data[7:0] != dl)
        data_ok = 1'b0;
    end
  end

  // All enabled compares must agree in the same bus cycle
  assign bp0_raw = (dual || full) && hit0 && (!full || data_ok);
  assign bp1_raw = dual && dbe && hit1;
  // Tagged breaks only count on opcode fetches
  assign any_hit = cpu_valid && !debug_active
                   && (bp0_raw || bp1_raw) && (!prog || cpu_fetch);
  assign can_bdm = debug_mode_enable;

  // Registered requests, one cycle per matching bus cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      swi_req_q <= 1'b0;
      bdm_req_q <= 1'b0;
      tag_req_q <= 1'b0;
    end else begin
      swi_req_q <= any_hit && (mode == HBU_SWI_DUAL);
      // Untagged debug entry happens at next instruction boundary
      bdm_req_q <= any_hit && !prog && (full ||
                   (mode == HBU_BDM_DUAL && can_bdm));
      // Tag rides the opcode; core enters debug at queue head
      tag_req_q <= any_hit && prog && (full || mode == HBU_SWI_DUAL ||
                   (mode == HBU_BDM_DUAL && can_bdm));
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  // Write address phase, then its data phase one cycle later
  sequence s_wr_addr;
    take && hwrite;
  endsequence
  sequence s_wr_data;
    state_q == HBU_ST_DATA && wr_pend_q;
  endsequence
  // Untagged full mode hit on a valid bus cycle
  sequence s_untagged_hit;
    cpu_valid && !debug_active && full && !prog && bp0_raw;
  endsequence

  // Request outputs against mode and debug state
  chk_no_bp_active: assert property (@(posedge clk)
    disable iff (reset)
    $past(debug_active) |-> !swi_req_q && !bdm_req_q && !tag_req_q)
    else $error("breakpoint while debug active");
  chk_swi_only_dual: assert property (@(posedge clk)
    disable iff (reset)
    swi_req_q |-> $past(mode) == HBU_SWI_DUAL)
    else $error("software interrupt outside dual interrupt mode");
  chk_swi_tagged: assert property (@(posedge clk)
    disable iff (reset)
    swi_req_q |-> tag_req_q && !bdm_req_q)
    else $error("interrupt mode break not tagged");
  chk_dual_enable: assert property (@(posedge clk)
    disable iff (reset)
    (bdm_req_q || tag_req_q) && $past(mode) == HBU_BDM_DUAL
      |-> $past(debug_mode_enable))
    else $error("dual debug entry without enable");
  chk_prog_fetch: assert property (@(posedge clk)
    disable iff (reset)
    tag_req_q |-> $past(cpu_fetch) && $past(prog))
    else $error("tag on non-fetch cycle");
  chk_off_quiet: assert property (@(posedge clk)
    disable iff (reset)
    $past(mode) == HBU_OFF |-> !(swi_req_q || bdm_req_q || tag_req_q))
    else $error("request with breakpoints off");
  chk_bdm_untagged: assert property (@(posedge clk)
    disable iff (reset)
    bdm_req_q |-> !$past(prog) && !swi_req_q)
    else $error("immediate debug request in tagged mode");
  chk_full_break: assert property (@(posedge clk)
    disable iff (reset)
    s_untagged_hit |=> bdm_req_q && !tag_req_q)
    else $error("untagged full mode hit without debug request");

  // Comparator results
  chk_bp0_addr: assert property (@(posedge clk)
    disable iff (reset)
    $past(bp0_raw) |-> $past(cpu_addr[15:8]) == $past(ah))
    else $error("first breakpoint high byte mismatch");
  chk_range_low: assert property (@(posedge clk)
    disable iff (reset)
    $past(bp0_raw) && $past(ctrl0_q[`HBU_C0_RANGE0])
      |-> $past(cpu_addr[7:0]) == $past(al))
    else $error("first breakpoint low byte ignored");
  chk_bp1_enable: assert property (@(posedge clk)
    disable iff (reset)
    bp1_raw |-> dbe && dual && cpu_addr[15:8] == dh)
    else $error("second breakpoint without data enable");
  chk_full_no_bp1: assert property (@(posedge clk)
    disable iff (reset)
    full |-> !bp1_raw)
    else $error("second breakpoint active in full mode");

  // Byte masks in full mode: an unmasked byte that differs blocks entry
  chk_high_mask: assert property (@(posedge clk)
    disable iff (reset)
    full && !prog && dbe && !ctrl1_q[`HBU_C1_MBH] && cpu_data[15:8] != dh
      |=> !bdm_req_q)
    else $error("unmasked high data byte ignored");
  chk_low_mask: assert property (@(posedge clk)
    disable iff (reset)
    full && !prog && dbe && !ctrl1_q[`HBU_C1_MBL] && cpu_data[7:0] != dl
      |=> !bdm_req_q)
    else $error("unmasked low data byte ignored");

  // Bus slave phases
  chk_write_phase: assert property (@(posedge clk)
    disable iff (reset)
    s_wr_addr |=> s_wr_data)
    else $error("write data phase not tracked");

  // Ordinary reset must leave the compare setup untouched
  chk_cmp_keep: assert property (@(posedge clk)
    !por && !cmp_we ##1 !por |-> $stable({ah, al, dh, dl}))
    else $error("compare registers changed without write");
endmodule // hbu_top

/* hbu_cpu_model.sv */
// Behavioural CPU bus that feeds cycles to the breakpoint unit
`timescale 1ns/1ps
module hbu_cpu_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        go,
  input  wire logic [15:0] a_in,
  input  wire logic [15:0] d_in,
  input  wire logic        rw_in,
  input  wire logic        f_in,
  output logic             cpu_valid,
  output logic [15:0]      cpu_addr,
  output logic [15:0]      cpu_data,
  output logic             cpu_rw,
  output logic             cpu_fetch
);
  // One bus cycle per request; idle cycles show changing junk values
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_valid <= 1'b0;
      cpu_addr  <= 16'h0000;
      cpu_data  <= 16'h0000;
      cpu_rw    <= 1'b0;
      cpu_fetch <= 1'b0;
    end else begin
      cpu_valid <= go;
      cpu_addr  <= go ? a_in : ~cpu_addr;
      cpu_data  <= go ? d_in : ~cpu_data;
      cpu_rw    <= go ? rw_in : ~cpu_rw;
      cpu_fetch <= go ? f_in : ~cpu_fetch;
    end
  end
endmodule // hbu_cpu_model

/* test_hardware_breakpoint_unit.sv */
// Self-checking testbench of the hardware breakpoint unit
`timescale 1ns/1ps
module test_hardware_breakpoint_unit;
  logic        clk, reset, por, hsel, hwrite, go, rw_in, f_in, dact, den;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] a_in, d_in, cpu_addr, cpu_data;
  logic        hreadyout, hresp, cpu_valid, cpu_rw, cpu_fetch;
  logic        swi_req_q, bdm_req_q, tag_req_q;
  logic [7:0]  r [0:5];
  integer      failures = 0, n_tests = 0, seed = 43082, cycles = 0, i, k;

  hbu_top i_hbu_top (.clk, .reset, .por, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .cpu_valid, .cpu_addr, .cpu_data, .cpu_rw, .cpu_fetch,
    .debug_active(dact), .debug_mode_enable(den), .swi_req_q, .bdm_req_q,
    .tag_req_q);
  hbu_cpu_model i_hbu_cpu_model (.clk, .reset, .go, .a_in, .d_in, .rw_in,
    .f_in, .cpu_valid, .cpu_addr, .cpu_data, .cpu_rw, .cpu_fetch);

  // Clock at 20 MHz
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      test_done();
    end
  end

  // ------------------------------------------------------------------
  // Checking and bus tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Single AHB transfer; waits for hready in both phases
  task automatic ahb(input logic w, input logic [7:0] ofs,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0000_0000);
  endtask

  // Shadow keeps what a read must return; unused bits read zero
  task automatic wr(input integer idx, input logic [7:0] v);
    logic [31:0] d;
    ahb(1'b1, 8'(idx * 4), {24'h000000, v}, d);
    r[idx] = v & (idx == 0 ? 8'hCB : idx == 1 ? 8'h7F : 8'hFF);
  endtask

  task automatic rd_all(input integer n);
    logic [31:0] d;
    for (k = 0; k < n; k++) begin
      ahb(1'b0, 8'(k * 4), 32'h00000000, d);
      chk(d, k < 6 ? {24'h000000, r[k]} : 32'h00000000);
    end
  endtask

  task automatic do_reset(input logic p);
    @(posedge clk);
    reset <= 1'b1;
    por <= p;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    r[0] = 8'h00;
    r[1] = 8'h00;
    if (p) for (k = 2; k < 6; k++) r[k] = 8'h00;
  endtask

  // Reference: expected {software, debug, tag} requests of one cycle
  function automatic logic [2:0] want(input logic [15:0] a, d,
                                      input logic rw, f, da, de);
    logic h0;
    logic h1;
    h0 = a[15:8] == r[2] && (!r[0][0] || a[7:0] == r[3]);
    h1 = r[1][6] && a[15:8] == r[4] && (!r[0][1] || a[7:0] == r[5]);
    if (da || r[0][7:6] == 2'h0) return 3'h0;
    if (r[0][7:6] == 2'h1) return {(h0 | h1) & f, 1'b0, (h0 | h1) & f};
    if (!r[0][3]) begin
      h0 &= !r[1][1] || rw == r[1][0];
      h1 &= !r[1][3] || rw == r[1][2];
    end
    if (r[0][7:6] == 2'h2) begin
      h1 = 1'b0;
      if (!r[0][3] && r[1][6]) h0 &= (r[1][5] || d[15:8] == r[4]) &&
                                     (r[1][4] || d[7:0] == r[5]);
    end else h0 = (h0 | h1) && de;
    return r[0][3] ? {2'h0, h0 & f} : {1'b0, h0, 1'b0};
  endfunction

  // One CPU cycle through the partner, then compare the request pulses
  task automatic cpu_rand;
    logic [15:0] a;
    logic [15:0] d;
    logic [31:0] s;
    s = $random(seed);
    a = 16'($random(seed));
    d = 16'($random(seed));
    if (s[0]) a[15:8] = s[1] ? r[2] : r[4];
    if (s[2]) a[7:0] = s[3] ? r[3] : r[5];
    if (s[4]) d[15:8] = r[4];
    if (s[5]) d[7:0] = r[5];
    @(posedge clk);
    go <= 1'b1;
    a_in <= a;
    d_in <= d;
    rw_in <= s[6];
    f_in <= s[7] | s[8];
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk({swi_req_q, bdm_req_q, tag_req_q},
        want(a, d, s[6], s[7] | s[8], dact, den));
    // Idle cycle shows junk on the bus; no request may follow it
    @(posedge clk);
    #1;
    chk({swi_req_q, bdm_req_q, tag_req_q}, 3'h0);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    {reset, por, hsel, hwrite, go, rw_in, f_in, dact, den} = 9'h180;
    {haddr, hwdata, htrans, a_in, d_in} = '0;
    hsize = 3'h2;
    for (k = 0; k < 6; k++) r[k] = 8'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    por <= 1'b0;
    rd_all(8);
    for (i = 0; i < 6; i++) wr(i, 8'($random(seed)));
    rd_all(6);
    do_reset(1'b0);
    rd_all(6);
    do_reset(1'b1);
    rd_all(6);
    // Modes rotate every pass so each one sees many random cycles
    for (i = 0; i < 240; i++) begin
      wr(0, {i[1:0], 6'($random(seed))});
      wr(1, 8'($random(seed)));
      if (i % 4 == 0) for (k = 2; k < 6; k++) wr(k, 8'($random(seed)));
      dact <= ($random(seed) & 7) == 0;
      den <= ($random(seed) & 3) != 0;
      for (k = 0; k < 4; k++) cpu_rand();
    end
    rd_all(6);
    test_done();
  end
endmodule // test_hardware_breakpoint_unit
